// ### include/sld_pkg.sv
// Function
// - Three independent red, green, blue sink channels
// - Current code linear, 3 mA per step
// - Duty zero off, 1-31 N/32, top bit on
// - Per-channel ramp enable bit
// - Ramp one 1/32 step every 1/64 s
// - Ramp on duty change, else immediate
// - Period code selects 1/256, 1/8, 1, 2 s
// - Blink on-time is duty fraction of period
// - Nonzero period code disables ramping
// - Boost request bit in blue control register
// - Boost enable is OR of three requests
// - Outputs usable as open-drain logic or PWM
package sld_pkg;
   localparam int unsigned CLK_HZ         = 10_000_000;
   localparam int unsigned SLOTS          = 32;
   localparam int unsigned RAMP_STEPS_HZ  = 64;
   localparam int unsigned SLOT_BASE_CYC  = CLK_HZ / (256 * SLOTS);
   localparam int unsigned RAMP_CYC       = CLK_HZ / RAMP_STEPS_HZ;
   localparam int unsigned MULT_P1        = 32;
   localparam int unsigned MULT_P2        = 256;
   localparam int unsigned MULT_P3        = 512;
   localparam logic [1:0]  PER_FAST       = 2'h0;
   localparam logic [1:0]  PER_EIGHTH     = 2'h1;
   localparam logic [1:0]  PER_ONE        = 2'h2;
   localparam logic [1:0]  PER_TWO        = 2'h3;
   localparam logic [5:0]  DUTY_FULL      = 6'h20;
   localparam logic [31:0] ADDR_RED       = 32'h0000_0000;
   localparam logic [31:0] ADDR_GREEN     = 32'h0000_0004;
   localparam logic [31:0] ADDR_BLUE      = 32'h0000_0008;
   localparam logic [31:0] ADDR_BOOST     = 32'h0000_000C;
   localparam logic [31:0] ADDR_STATUS    = 32'h0000_0010;
   localparam int          F_LVL          = 0;
   localparam int          F_DUTY         = 3;
   localparam int          F_RAMP         = 9;
   localparam int          F_PER          = 10;
   localparam int          F_LBST         = 12;
   localparam int          F_GBST         = 0;
   localparam int          F_UBST         = 1;
   localparam logic [1:0]  RESP_OKAY      = 2'h0;
   localparam logic [1:0]  RESP_SLVERR    = 2'h2;
   localparam int          CTRL_W         = 12;
endpackage : sld_pkg

// ### verilog/sld_top.sv
module sld_top
   import sld_pkg::*;
(
   // Clock and reset
   input  wire logic        clk_sys,
   input  wire logic        rstn,
   // AXI4-Lite write
   input  wire logic [31:0] s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   // AXI4-Lite read
   input  wire logic [31:0] s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   // Sink outputs, open drain: oe high pulls the pin low
   output logic             red_sink_output_oe,
   output logic             green_sink_output_oe,
   output logic             blue_sink_output_oe,
   output logic [2:0]       red_current_level,
   output logic [2:0]       green_current_level,
   output logic [2:0]       blue_current_level,
   // Boost converter enable
   output logic             boost_converter_en
);
   import sld_pkg::*;

   logic [CTRL_W-1:0] ctrl_r [3];
   logic              lbst_r;
   logic              gbst_r;
   logic              ubst_r;
   logic [5:0]        act_r [3];
   logic [2:0]        wr_chg;

   // Write channel: address and data captured in either order
   logic [31:0] awaddr_r;
   logic [31:0] wdata_r;
   logic [3:0]  wstrb_r;
   logic        aw_have_r;
   logic        w_have_r;
   logic        do_wr;
   logic        wr_hit;

   assign do_wr  = aw_have_r && w_have_r && !s_axi_bvalid;
   assign wr_hit = awaddr_r == ADDR_RED || awaddr_r == ADDR_GREEN || awaddr_r == ADDR_BLUE
                   || awaddr_r == ADDR_BOOST || awaddr_r == ADDR_STATUS;

   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         aw_have_r     <= 1'b0;
         w_have_r      <= 1'b0;
         awaddr_r      <= 32'h0000_0000;
         wdata_r       <= 32'h0000_0000;
         wstrb_r       <= 4'h0;
         s_axi_awready <= 1'b0;
         s_axi_wready  <= 1'b0;
         s_axi_bvalid  <= 1'b0;
         s_axi_bresp   <= RESP_OKAY;
      end else begin
         s_axi_awready <= !aw_have_r && !s_axi_awready && s_axi_awvalid;
         s_axi_wready  <= !w_have_r && !s_axi_wready && s_axi_wvalid;
         if (s_axi_awvalid && s_axi_awready) begin
            aw_have_r <= 1'b1;
            awaddr_r  <= {s_axi_awaddr[31:2], 2'h0};
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_have_r <= 1'b1;
            wdata_r  <= s_axi_wdata;
            wstrb_r  <= s_axi_wstrb;
         end
         if (do_wr) begin
            aw_have_r    <= 1'b0;
            w_have_r     <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wr_hit ? RESP_OKAY : RESP_SLVERR;
         end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   // Channel control registers, one per colour
   generate
      for (genvar c = 0; c < 3; c++) begin : g_ctrl
         logic [31:0] addr_c;
         logic [CTRL_W-1:0] merged;
         assign addr_c = (c == 0) ? ADDR_RED : (c == 1) ? ADDR_GREEN : ADDR_BLUE;
         always_comb begin
            merged = ctrl_r[c];
            if (wstrb_r[0])
               merged[7:0] = wdata_r[7:0];
            if (wstrb_r[1])
               merged[CTRL_W-1:8] = wdata_r[CTRL_W-1:8];
         end
         assign wr_chg[c] = do_wr && awaddr_r == addr_c
                            && merged[F_DUTY+5:F_DUTY] != ctrl_r[c][F_DUTY+5:F_DUTY];
         always_ff @(posedge clk_sys) begin
            if (!rstn)
               ctrl_r[c] <= '0;
            else if (do_wr && awaddr_r == addr_c)
               ctrl_r[c] <= merged;
         end
      end
   endgenerate

   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         lbst_r <= 1'b0;
         gbst_r <= 1'b0;
         ubst_r <= 1'b0;
      end else if (do_wr) begin
         if (awaddr_r == ADDR_BLUE && wstrb_r[1])
            lbst_r <= wdata_r[F_LBST];
         if (awaddr_r == ADDR_BOOST && wstrb_r[0]) begin
            gbst_r <= wdata_r[F_GBST];
            ubst_r <= wdata_r[F_UBST];
         end
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!rstn)
         boost_converter_en <= 1'b0;
      else
         boost_converter_en <= gbst_r | ubst_r | lbst_r;
   end

   // Read channel
   logic [31:0] rd_val;
   logic        rd_hit;
   always_comb begin
      rd_hit = 1'b1;
      rd_val = 32'h0000_0000;
      unique case ({s_axi_araddr[31:2], 2'h0})
         ADDR_RED:    rd_val[CTRL_W-1:0] = ctrl_r[0];
         ADDR_GREEN:  rd_val[CTRL_W-1:0] = ctrl_r[1];
         ADDR_BLUE: begin
            rd_val[CTRL_W-1:0] = ctrl_r[2];
            rd_val[F_LBST]     = lbst_r;
         end
         ADDR_BOOST: begin
            rd_val[F_GBST] = gbst_r;
            rd_val[F_UBST] = ubst_r;
         end
         ADDR_STATUS: rd_val[17:0] = {act_r[2], act_r[1], act_r[0]};
         default:     rd_hit = 1'b0;
      endcase
   end

   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= 32'h0000_0000;
         s_axi_rresp   <= RESP_OKAY;
      end else begin
         s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
         if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= rd_val;
            s_axi_rresp  <= rd_hit ? RESP_OKAY : RESP_SLVERR;
         end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end

   // Shared timebase: slot tick for the fast period and ramp tick
   logic [15:0] base_cnt_r;
   logic        base_tick;
   logic [17:0] ramp_cnt_r;
   logic        ramp_tick;
   assign base_tick = base_cnt_r == 16'(SLOT_BASE_CYC - 1);
   assign ramp_tick = ramp_cnt_r == 18'(RAMP_CYC - 1);
   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         base_cnt_r <= 16'h0000;
         ramp_cnt_r <= 18'h0_0000;
      end else begin
         base_cnt_r <= base_tick ? 16'h0000 : base_cnt_r + 16'h0001;
         ramp_cnt_r <= ramp_tick ? 18'h0_0000 : ramp_cnt_r + 18'h0_0001;
      end
   end

   logic [2:0] sink_r;

   generate
      for (genvar c = 0; c < 3; c++) begin : g_chan
         logic [5:0]  tgt;
         logic [1:0]  per;
         logic        rmp_en;
         logic        ramping_r;
         logic [9:0]  mult_cnt_r;
         logic [9:0]  mult_end;
         logic        slot_tick;
         logic [4:0]  slot_r;
         assign per    = ctrl_r[c][F_PER+1:F_PER];
         assign rmp_en = ctrl_r[c][F_RAMP] && per == PER_FAST;
         // Top bit set means continuously on
         assign tgt    = ctrl_r[c][F_DUTY+5] ? DUTY_FULL : {1'b0, ctrl_r[c][F_DUTY+4:F_DUTY]};

         // Active duty tracks target, gradually when ramping
         always_ff @(posedge clk_sys) begin
            if (!rstn) begin
               act_r[c]  <= 6'h00;
               ramping_r <= 1'b0;
            end else if (!rmp_en) begin
               // A write that sets the ramp bit and a new duty still ramps
               act_r[c]  <= tgt;
               ramping_r <= wr_chg[c];
            end else begin
               if (wr_chg[c])
                  ramping_r <= 1'b1;
               if ((ramping_r || wr_chg[c]) && ramp_tick) begin
                  if (act_r[c] < tgt)
                     act_r[c] <= act_r[c] + 6'h01;
                  else if (act_r[c] > tgt)
                     act_r[c] <= act_r[c] - 6'h01;
                  else
                     ramping_r <= wr_chg[c];
               end
            end
         end

         // Slot length: fast period uses base tick directly
         always_comb begin
            unique case (per)
               PER_FAST:   mult_end = 10'h000;
               PER_EIGHTH: mult_end = 10'(MULT_P1 - 1);
               PER_ONE:    mult_end = 10'(MULT_P2 - 1);
               PER_TWO:    mult_end = 10'(MULT_P3 - 1);
            endcase
         end
         assign slot_tick = base_tick && mult_cnt_r >= mult_end;
         always_ff @(posedge clk_sys) begin
            if (!rstn) begin
               mult_cnt_r <= 10'h000;
               slot_r     <= 5'h00;
            end else if (base_tick) begin
               mult_cnt_r <= slot_tick ? 10'h000 : mult_cnt_r + 10'h001;
               if (slot_tick)
                  slot_r <= slot_r + 5'h01;
            end
         end

         // Sink on during first N slots of each period
         always_ff @(posedge clk_sys) begin
            if (!rstn)
               sink_r[c] <= 1'b0;
            else
               sink_r[c] <= {1'b0, slot_r} < act_r[c];
         end
      end
   endgenerate

   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         red_current_level   <= 3'h0;
         green_current_level <= 3'h0;
         blue_current_level  <= 3'h0;
      end else begin
         // Code times 3 mA, decoded by the analog sink
         red_current_level   <= ctrl_r[0][F_LVL+2:F_LVL];
         green_current_level <= ctrl_r[1][F_LVL+2:F_LVL];
         blue_current_level  <= ctrl_r[2][F_LVL+2:F_LVL];
      end
   end

   assign red_sink_output_oe   = sink_r[0];
   assign green_sink_output_oe = sink_r[1];
   assign blue_sink_output_oe  = sink_r[2];
endmodule : sld_top

// ### verif/sld_asserts.sv
module sld_asserts
   import sld_pkg::*;
(
   // Clock and reset
   input wire logic        clk_sys,
   input wire logic        rstn,
   // Register bus
   input wire logic [31:0] s_axi_awaddr,
   input wire logic        s_axi_awvalid,
   input wire logic        s_axi_awready,
   input wire logic        s_axi_wready,
   input wire logic [1:0]  s_axi_bresp,
   input wire logic        s_axi_bvalid,
   input wire logic        s_axi_bready,
   input wire logic        s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic        s_axi_rvalid,
   input wire logic        s_axi_rready,
   // Channels
   input wire logic        red_sink_output_oe,
   input wire logic        blue_sink_output_oe,
   input wire logic [2:0]  red_current_level,
   input wire logic [2:0]  blue_current_level,
   input wire logic        boost_converter_en
);
   timeunit 1ns;
   timeprecision 1ns;
   logic bad_r;
   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         bad_r <= 1'b0;
      end else if (s_axi_awvalid && s_axi_awready) begin
         bad_r <= {s_axi_awaddr[31:2], 2'h0} > ADDR_STATUS;
      end
   end
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!rstn);
   a_aw_pulse: assert property (s_axi_awready |=> !s_axi_awready) else $error("awready held");
   a_w_pulse: assert property (s_axi_wready |=> !s_axi_wready) else $error("wready held");
   a_read_answer: assert property (s_axi_arready |=> s_axi_rvalid) else $error("no read answer");
   a_read_stands: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read data dropped");
   a_write_stands: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write response dropped");
   a_write_resp: assert property (s_axi_bvalid |-> s_axi_bresp == (bad_r ? RESP_SLVERR : RESP_OKAY))
      else $error("wrong write response");
   a_level_write: assert property ($changed({red_current_level, blue_current_level}) |-> $past(s_axi_bvalid))
      else $error("level changed without write");
   a_boost_write: assert property ($changed(boost_converter_en) |-> $past(s_axi_bvalid))
      else $error("boost changed without write");
   a_reset_quiet: assert property (disable iff (1'b0) !rstn |=> !boost_converter_en && !red_sink_output_oe
      && !blue_sink_output_oe && red_current_level == 3'h0) else $error("outputs active in reset");
   c_write_ok: cover property (s_axi_bvalid && s_axi_bresp == RESP_OKAY);
   c_write_err: cover property (s_axi_bvalid && s_axi_bresp == RESP_SLVERR);
   c_blue_on: cover property (boost_converter_en && blue_sink_output_oe);
endmodule : sld_asserts

bind sld_top sld_asserts sld_asserts_i (.clk_sys, .rstn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
   .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid,
   .s_axi_rready, .red_sink_output_oe, .blue_sink_output_oe, .red_current_level, .blue_current_level,
   .boost_converter_en);

// ### verif/sld_leds.sv
module sld_leds (
   // Clock and control
   input wire logic        clk_sys,
   input wire logic        clr,
   // Pins, pulled up, low while sinking
   input wire logic [2:0]  pin,
   // Sinking cycles per channel
   output logic     [31:0] on_cnt [3]
);
   timeunit 1ns;
   timeprecision 1ns;
   always_ff @(posedge clk_sys) begin
      for (int i = 0; i < 3; i++) begin
         on_cnt[i] <= clr ? 32'h0 : on_cnt[i] + {31'h0, !pin[i]};
      end
   end
endmodule : sld_leds

// ### verif/test_signal_led_pwm_driver.sv
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin n_fail++; \
   $display("CHECK FAILED t=%0t got %h exp %h", $time, g, e); end end
module test_signal_led_pwm_driver;
   timeunit 1ns;
   timeprecision 1ns;
   import sld_pkg::*;
   typedef struct { logic [31:0] a; logic [31:0] d; logic bst; } sld_row_t;
   logic        clk_sys = 1'b0, rstn = 1'b0, clr = 1'b0;
   logic [31:0] s_axi_awaddr = 32'h0, s_axi_wdata = 32'h0, s_axi_araddr = 32'h0;
   logic [3:0]  s_axi_wstrb = 4'hF;
   logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   wire logic   s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, boost_converter_en;
   wire logic   red_sink_output_oe, green_sink_output_oe, blue_sink_output_oe;
   wire logic [1:0]  s_axi_bresp, s_axi_rresp;
   wire logic [31:0] s_axi_rdata;
   wire logic [2:0]  red_current_level, green_current_level, blue_current_level, pin;
   logic      [31:0] on_cnt [3];
   int          n_fail = 0, checked = 0;
   wire logic [12:0] outs = {boost_converter_en, blue_sink_output_oe, green_sink_output_oe, red_sink_output_oe,
                             blue_current_level, green_current_level, red_current_level};
   // Colour by level, intensity by duty
   sld_row_t rows [8] = '{'{ADDR_RED, 32'h0000_002D, 1'b0}, '{ADDR_GREEN, 32'h0000_0007, 1'b0},
      '{ADDR_BLUE, 32'h0000_11F9, 1'b1}, '{ADDR_BOOST, 32'h0000_0002, 1'b1},
      '{ADDR_BLUE, 32'h0000_01F9, 1'b1}, '{ADDR_BOOST, 32'h0000_0001, 1'b1},
      '{ADDR_BOOST, 32'h0000_0000, 1'b0}, '{ADDR_BLUE, 32'h0000_11F9, 1'b1}};
   assign pin = ~{blue_sink_output_oe, green_sink_output_oe, red_sink_output_oe};
   sld_top sld_top_i (.clk_sys, .rstn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
      .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
      .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .red_sink_output_oe,
      .green_sink_output_oe, .blue_sink_output_oe, .red_current_level, .green_current_level,
      .blue_current_level, .boost_converter_en);
   sld_leds sld_leds_i (.clk_sys, .clr, .pin, .on_cnt);
   initial begin
      forever #50 clk_sys = ~clk_sys;
   end
   task automatic give_verdict;
      $display("checked %0d n_fail %0d", checked, n_fail);
      if (n_fail == 0 && checked > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask : give_verdict
   task automatic wait_bound(input int k);
      if (k >= 64) begin
         n_fail++;
         give_verdict();
      end
   endtask : wait_bound
   task automatic axw(input logic [31:0] a, input logic [31:0] d, input logic [1:0] er);
      logic pa;
      logic pw;
      int   k;
      pa = 1'b1;
      pw = 1'b1;
      @(posedge clk_sys);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      for (k = 0; k < 64 && (pa || pw); k++) begin
         @(negedge clk_sys);
         pa = pa && s_axi_awready !== 1'b1;
         pw = pw && s_axi_wready !== 1'b1;
         @(posedge clk_sys);
         s_axi_awvalid <= pa;
         s_axi_wvalid <= pw;
      end
      wait_bound(k);
      for (k = 0; k < 64; k++) begin
         @(negedge clk_sys);
         if (s_axi_bvalid === 1'b1) break;
      end
      wait_bound(k);
      `CHK(s_axi_bresp, er)
      @(posedge clk_sys);
      s_axi_bready <= 1'b0;
   endtask : axw
   task automatic axr(input logic [31:0] a, input logic [31:0] d, input logic [1:0] er);
      int k;
      @(posedge clk_sys);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      for (k = 0; k < 64; k++) begin
         @(negedge clk_sys);
         if (s_axi_arready === 1'b1) break;
      end
      wait_bound(k);
      @(posedge clk_sys);
      s_axi_arvalid <= 1'b0;
      for (k = 0; k < 64; k++) begin
         @(negedge clk_sys);
         if (s_axi_rvalid === 1'b1) break;
      end
      wait_bound(k);
      `CHK(s_axi_rresp, er)
      if (er == RESP_OKAY) `CHK(s_axi_rdata, d)
      @(posedge clk_sys);
      s_axi_rready <= 1'b0;
   endtask : axr
   initial begin
      repeat (20) @(posedge clk_sys);
      `CHK(outs, 13'h0000)
      rstn <= 1'b1;
      axr(ADDR_STATUS, 32'h0, RESP_OKAY);
      foreach (rows[i]) begin
         axw(rows[i].a, rows[i].d, RESP_OKAY);
         axr(rows[i].a, rows[i].d, RESP_OKAY);
         `CHK(boost_converter_en, rows[i].bst)
      end
      `CHK({blue_current_level, green_current_level, red_current_level}, {3'h1, 3'h7, 3'h5})
      axr(ADDR_STATUS, {14'h0, DUTY_FULL, 12'h005}, RESP_OKAY);
      axw(32'h0000_0040, 32'hFFFF_FFFF, RESP_SLVERR);
      axr(32'h0000_0040, 32'h0, RESP_SLVERR);
      axr(ADDR_RED, 32'h0000_002D, RESP_OKAY);
      // Byte 1 enabled only: byte 0 must keep its old value
      s_axi_wstrb <= 4'h2;
      axw(ADDR_RED, 32'h0000_00FF, RESP_OKAY);
      axr(ADDR_RED, 32'h0000_002D, RESP_OKAY);
      s_axi_wstrb <= 4'hF;
      axw(ADDR_RED, 32'h0000_064D, RESP_OKAY);
      axr(ADDR_STATUS, {14'h0, DUTY_FULL, 12'h009}, RESP_OKAY);
      axw(ADDR_RED, 32'h0000_02A5, RESP_OKAY);
      axr(ADDR_STATUS, {14'h0, DUTY_FULL, 12'h009}, RESP_OKAY);
      axw(ADDR_RED, 32'h0000_002D, RESP_OKAY);
      axr(ADDR_STATUS, {14'h0, DUTY_FULL, 12'h005}, RESP_OKAY);
      @(posedge clk_sys);
      clr <= 1'b1;
      @(posedge clk_sys);
      clr <= 1'b0;
      repeat (SLOTS * SLOT_BASE_CYC) @(posedge clk_sys);
      @(negedge clk_sys);
      `CHK(on_cnt[0], 32'(5 * SLOT_BASE_CYC))
      `CHK(on_cnt[1], 32'h0)
      `CHK(on_cnt[2], 32'(SLOTS * SLOT_BASE_CYC))
      @(posedge clk_sys);
      rstn <= 1'b0;
      repeat (3) @(posedge clk_sys);
      `CHK(outs, 13'h0000)
      rstn <= 1'b1;
      axr(ADDR_BLUE, 32'h0, RESP_OKAY);
      give_verdict();
   end
endmodule : test_signal_led_pwm_driver
